// *** hw/scia_pkg.sv ***
/*
 Constants shared by the smart card character engine: register map,
 control and event bit positions, reset values, sequencer and power states.
 Assumes a 20 MHz bus clock and byte-wide registers, one per 32-bit word.
*/
package scia_pkg;
    // Register byte addresses; wide values keep their low byte highest
    localparam logic [5:0] A_CTRL = 6'h00;
    localparam logic [5:0] A_STAT = 6'h04;
    localparam logic [5:0] A_ISR = 6'h08;
    localparam logic [5:0] A_IER = 6'h0C;
    localparam logic [5:0] A_TXB = 6'h10;
    localparam logic [5:0] A_RXB = 6'h14;
    localparam logic [5:0] A_ETU1 = 6'h18;
    localparam logic [5:0] A_ETU0 = 6'h1C;
    localparam logic [5:0] A_GT1 = 6'h20;
    localparam logic [5:0] A_GT0 = 6'h24;
    localparam logic [5:0] A_WT2 = 6'h28;
    localparam logic [5:0] A_WT1 = 6'h2C;
    localparam logic [5:0] A_WT0 = 6'h30;
    localparam logic [5:0] A_MAN = 6'h34;
    // Control bits; ETU_COMP is bit 7 of the ETU high byte
    localparam int C_UART = 0;
    localparam int C_WAIT_COUNTER_ENABLE = 1;
    localparam int C_INV = 2;
    localparam int C_REP = 3;
    localparam int C_ACT = 4;
    localparam int ETU_COMP = 7;
    // Event bits
    localparam int EV_RX = 0;
    localparam int EV_TX = 1;
    localparam int EV_PAR = 2;
    localparam int EV_WTO = 3;
    localparam int EV_INS = 4;
    localparam int EV_REM = 5;
    // Reset values
    localparam logic [7:0] ETU1_RST = 8'h01;
    localparam logic [7:0] ETU0_RST = 8'h74;
    localparam logic [7:0] GT0_RST = 8'h0C;
    localparam logic [7:0] WT2_RST = 8'h00;
    localparam logic [7:0] WT1_RST = 8'h25;
    localparam logic [7:0] WT0_RST = 8'h80;
    // Bit positions within a character frame, counted in ETU ticks
    localparam logic [3:0] B_PAR = 4'h9;
    localparam logic [3:0] B_REL = 4'hA;
    localparam logic [3:0] B_ERR = 4'hB;
    // Power sequence step time
    localparam int CLK_MHZ = 20;
    localparam int PWR_STEP_NS = 1000;
    localparam logic [7:0] PWR_STEP = 8'((PWR_STEP_NS * CLK_MHZ) / 1000);
    typedef enum logic [1:0] {S_IDLE, S_TX, S_RX, S_RXEND} scia_seq_t;
    typedef enum logic [1:0] {P_OFF, P_ACT, P_ON, P_DEACT} scia_pwr_t;
endpackage

// *** hw/scia_core.sv ***
/*
 Smart card asynchronous character engine with AHB-Lite register slave.
 Assumes card_clk, card_present and card_io_in are asynchronous to hclk
 and that the card I/O line is open drain with a pull-up outside.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Shifter converts serial line and bytes
// - Shifter keeps sent character for repeat
// - Direct or inverse order and inversion
// - Parity generated and checked
// - Separate transmit and receive buffers
// - Sequencer runs only in UART mode
// - Receive to transmit, transmit wins
// - 11-bit ETU divider on card clock
// - Compensation alternates n and n-1
// - ETU high byte bit 7 enables compensation
// - 9-bit guard counter per ETU
// - 24-bit waiting down counter per ETU
// - Waiting timeout interrupts and locks interface
// - Top byte write loads when enable low
// - Enable edges start, stop, recover counter
// - UART mode reloads on start bit
// - No power-up without card present
// - Card removal starts deactivation
// - One irq, cleared by source read
// - Events during source read deferred
// - Low byte at highest address
// - Auto repeat and error signal
// - Insert and remove interrupts
module scia_core
    import scia_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic card_clk,
    input wire logic card_present,
    input wire logic card_io_in,
    output logic card_io_out,
    output logic card_io_oe,
    output logic card_vcc_en,
    output logic card_rst_n,
    output logic card_interface_irq
);
    typedef struct packed {
        logic [2:0] cs;
        logic [2:0] ps;
        logic [1:0] is;
        logic a_en;
        logic a_wr;
        logic [5:0] a_adr;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic man;
        logic [5:0] ier;
        logic [5:0] isr;
        logic [5:0] defer;
        logic [7:0] txbuf;
        logic tx_full;
        logic [7:0] rxbuf;
        logic rx_full;
        logic rep;
        logic [7:0] etu1;
        logic [7:0] etu0;
        logic gt1;
        logic [7:0] gt0;
        logic [7:0] wt2;
        logic [7:0] wt1;
        logic [7:0] wt0;
        logic [10:0] etu_cnt;
        logic half;
        logic [8:0] gt_cnt;
        logic [23:0] wt_cnt;
        logic wt_run;
        logic wait_counter_enable_d;
        logic locked;
        logic [1:0] rec;
        scia_seq_t seq;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic perr;
        logic drv;
        scia_pwr_t pwr;
        logic [7:0] pcnt;
        logic vcc;
        logic crst_n;
        logic pdrive;
    } scia_st_t;

    scia_st_t st;
    scia_st_t nx;
    logic [10:0] n;
    logic [10:0] per;
    logic tick;
    logic wr;
    logic wr_top;
    logic rd_isr;
    logic pres;
    logic io;
    logic inv;
    logic rise;
    logic fall;
    logic run_seq;
    logic [5:0] ev;
    logic [7:0] rb;

    // Line bit for the shifter's outgoing end, with convention applied
    function automatic logic out_bit(input logic [7:0] s, input logic i);
        out_bit = i ? ~s[7] : s[0];
    endfunction

    // Rotate so that eight shifts restore the character
    function automatic logic [7:0] rot(input logic [7:0] s, input logic i,
        input logic b);
        rot = i ? {s[6:0], b} : {b, s[7:1]};
    endfunction

    // Whole next state
    always_comb
    begin
        nx = st;
        ev = '0;
        rb = '0;
        rd_isr = 1'b0;
        nx.cs = {st.cs[1:0], card_clk};
        nx.ps = {st.ps[1:0], card_present};
        nx.is = {st.is[0], card_io_in};
        pres = st.ps[1];
        io = st.is[1];
        inv = st.ctrl[C_INV];
        n = {st.etu1[2:0], st.etu0};
        // Every second period, not the first, one cycle short when compensating
        per = (st.etu1[ETU_COMP] && st.half) ? n - 11'h001 : n;
        tick = 1'b0;
        // ETU divider on card clock rising edges
        if (st.cs[1] && !st.cs[2])
        begin
            if (st.etu_cnt + 11'h001 >= per)
            begin
                tick = 1'b1;
                nx.etu_cnt = '0;
                nx.half = ~st.half;
            end
            else
                nx.etu_cnt = st.etu_cnt + 11'h001;
        end
        // Guard counter saturates at its top
        if (tick && st.gt_cnt != 9'h1FF)
            nx.gt_cnt = st.gt_cnt + 9'h001;

        // Address phase: latch request and read data
        nx.a_en = hsel && htrans[1] && hready;
        nx.a_wr = hwrite;
        nx.a_adr = haddr[5:0];
        if (hsel && htrans[1] && hready && !hwrite && haddr[31:6] == '0)
        begin
            case (haddr[5:0])
                A_CTRL: rb = st.ctrl;
                A_STAT: rb = {2'h0, st.pwr == P_ON, pres, st.locked,
                    ~st.tx_full, st.rx_full, st.wt_run};
                A_ISR:
                begin
                    rb = {2'h0, st.isr | st.defer};
                    rd_isr = 1'b1;
                end
                A_IER: rb = {2'h0, st.ier};
                A_TXB: rb = st.txbuf;
                A_RXB:
                begin
                    rb = st.rxbuf;
                    nx.rx_full = 1'b0;
                end
                A_ETU1: rb = st.etu1;
                A_ETU0: rb = st.etu0;
                A_GT1: rb = {7'h0, st.gt1};
                A_GT0: rb = st.gt0;
                A_WT2: rb = st.wt2;
                A_WT1: rb = st.wt1;
                A_WT0: rb = st.wt0;
                A_MAN: rb = {7'h0, st.man};
                default: rb = '0;
            endcase
        end
        nx.rdata = {24'h0, rb};

        // Data phase writes
        wr = st.a_en && st.a_wr && hready;
        wr_top = wr && st.a_adr == A_WT2;
        if (wr)
        begin
            case (st.a_adr)
                A_CTRL: nx.ctrl = hwdata[7:0];
                A_IER: nx.ier = hwdata[5:0];
                A_TXB:
                begin
                    nx.txbuf = hwdata[7:0];
                    nx.tx_full = 1'b1;
                end
                A_ETU1: nx.etu1 = hwdata[7:0];
                A_ETU0: nx.etu0 = hwdata[7:0];
                A_GT1: nx.gt1 = hwdata[0];
                A_GT0: nx.gt0 = hwdata[7:0];
                A_WT2: nx.wt2 = hwdata[7:0];
                A_WT1: nx.wt1 = hwdata[7:0];
                A_WT0: nx.wt0 = hwdata[7:0];
                A_MAN: nx.man = hwdata[0];
                default: nx.man = st.man;
            endcase
        end

        // Waiting counter enable edges and recovery after timeout
        nx.wait_counter_enable_d = st.ctrl[C_WAIT_COUNTER_ENABLE];
        rise = st.ctrl[C_WAIT_COUNTER_ENABLE] && !st.wait_counter_enable_d;
        fall = !st.ctrl[C_WAIT_COUNTER_ENABLE] && st.wait_counter_enable_d;
        if (fall)
            nx.wt_run = 1'b0;
        if (st.locked)
        begin
            if (fall)
                nx.rec = 2'h1;
            else if (st.rec == 2'h1 && wr_top && !st.ctrl[C_WAIT_COUNTER_ENABLE])
                nx.rec = 2'h2;
            else if (st.rec == 2'h2 && rise)
            begin
                nx.locked = 1'b0;
                nx.rec = 2'h0;
                nx.wt_run = 1'b1;
            end
        end
        else if (rise)
            nx.wt_run = 1'b1;
        // Load all three bytes on top byte write while disabled
        if (wr_top && !st.ctrl[C_WAIT_COUNTER_ENABLE])
            nx.wt_cnt = {hwdata[7:0], st.wt1, st.wt0};
        else if (tick && st.wt_run && !st.locked && st.wt_cnt != '0)
        begin
            nx.wt_cnt = st.wt_cnt - 24'h000001;
            if (st.wt_cnt == 24'h000001)
            begin
                nx.locked = 1'b1;
                nx.rec = 2'h0;
                ev[EV_WTO] = 1'b1;
            end
        end

        // Character sequencer
        run_seq = st.ctrl[C_UART] && st.pwr == P_ON && !st.locked;
        case (st.seq)
            S_IDLE:
            begin
                nx.drv = 1'b0;
                // Transmit first once guard time has run out
                if (run_seq && (st.tx_full || st.rep)
                    && st.gt_cnt >= {st.gt1, st.gt0})
                begin
                    nx.seq = S_TX;
                    nx.drv = 1'b1;
                    nx.bitn = '0;
                    nx.etu_cnt = '0;
                    nx.half = 1'b0;
                    nx.gt_cnt = '0;
                    nx.rep = 1'b0;
                    if (!st.rep)
                    begin
                        nx.sh = st.txbuf;
                        nx.tx_full = wr && st.a_adr == A_TXB; // Fresh write stays
                    end
                    if (st.ctrl[C_WAIT_COUNTER_ENABLE])
                        nx.wt_cnt = {st.wt2, st.wt1, st.wt0};
                end
                else if (run_seq && !io)
                begin
                    nx.seq = S_RX;
                    nx.bitn = '0;
                    nx.perr = 1'b0;
                    nx.etu_cnt = {1'b0, n[10:1]};
                    nx.half = 1'b0;
                    if (st.ctrl[C_WAIT_COUNTER_ENABLE])
                        nx.wt_cnt = {st.wt2, st.wt1, st.wt0};
                end
            end
            S_TX:
            begin
                if (tick)
                begin
                    nx.bitn = st.bitn + 4'h1;
                    if (st.bitn < 4'h8)
                    begin
                        nx.drv = ~out_bit(st.sh, inv);
                        nx.sh = rot(st.sh, inv, st.sh[inv ? 7 : 0]);
                    end
                    else if (st.bitn + 4'h1 == B_PAR)
                        nx.drv = ~(^st.sh ^ inv);
                    else if (st.bitn + 4'h1 == B_REL)
                        nx.drv = 1'b0;
                    else
                    begin
                        nx.seq = S_IDLE;
                        if (!io && st.ctrl[C_REP])
                            nx.rep = 1'b1;
                        else
                            ev[EV_TX] = 1'b1;
                    end
                end
            end
            S_RX:
            begin
                if (tick)
                begin
                    nx.bitn = st.bitn + 4'h1;
                    if (st.bitn == '0 && io)
                        nx.seq = S_IDLE;
                    else if (st.bitn != '0 && st.bitn < B_PAR)
                        nx.sh = rot(st.sh, inv, io ^ inv);
                    else if (st.bitn == B_PAR)
                    begin
                        nx.seq = S_RXEND;
                        nx.bitn = '0;
                        nx.perr = ^st.sh ^ io ^ inv;
                        if (^st.sh ^ io ^ inv)
                            ev[EV_PAR] = 1'b1;
                        else
                        begin
                            nx.rxbuf = st.sh;
                            nx.rx_full = 1'b1;
                            ev[EV_RX] = 1'b1;
                        end
                    end
                end
            end
            S_RXEND:
            begin
                // Error signal for one ETU, then back to idle on the next tick
                if (tick)
                begin
                    nx.bitn = st.bitn + 4'h1;
                    nx.drv = st.bitn == '0 && st.perr && st.ctrl[C_REP];
                    if (st.bitn != '0)
                        nx.seq = S_IDLE;
                end
            end
            default: nx.seq = S_IDLE;
        endcase
        if (!run_seq)
        begin
            nx.seq = S_IDLE;
            nx.drv = 1'b0;
        end

        // Power sequencing and presence
        if (pres && !st.ps[2])
            ev[EV_INS] = 1'b1;
        if (!pres && st.ps[2])
        begin
            ev[EV_REM] = 1'b1;
            nx.ctrl[C_ACT] = 1'b0;
        end
        nx.pcnt = st.pcnt + 8'h01;
        case (st.pwr)
            P_OFF:
            begin
                nx.pcnt = '0;
                if (st.ctrl[C_ACT] && pres)
                    nx.pwr = P_ACT;
            end
            P_ACT:
            begin
                nx.vcc = 1'b1;
                if (!pres || !st.ctrl[C_ACT])
                begin
                    nx.pwr = P_DEACT;
                    nx.pcnt = '0;
                end
                else if (st.pcnt == PWR_STEP)
                begin
                    nx.crst_n = 1'b1;
                    nx.pwr = P_ON;
                end
            end
            P_ON:
            begin
                if (!pres || !st.ctrl[C_ACT])
                begin
                    nx.pwr = P_DEACT;
                    nx.pcnt = '0;
                end
            end
            P_DEACT:
            begin
                // Reset low, then I/O low, then supply off
                nx.crst_n = 1'b0;
                if (st.pcnt == PWR_STEP)
                    nx.pdrive = 1'b1;
                if (st.pcnt == PWR_STEP + PWR_STEP)
                begin
                    nx.vcc = 1'b0;
                    nx.pdrive = 1'b0;
                    nx.pwr = P_OFF;
                end
            end
            default: nx.pwr = P_OFF;
        endcase

        // Sticky sources; events during a source read wait one cycle
        nx.isr = rd_isr ? 6'h00 : st.isr | ev | st.defer;
        nx.defer = rd_isr ? ev : 6'h00;
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '0;
            st.etu1 <= ETU1_RST;
            st.etu0 <= ETU0_RST;
            st.gt0 <= GT0_RST;
            st.gt_cnt <= 9'h1FF;
            st.wt2 <= WT2_RST;
            st.wt1 <= WT1_RST;
            st.wt0 <= WT0_RST;
            st.seq <= S_IDLE;
            st.pwr <= P_OFF;
        end
        else
            st <= nx;
    end

    // Outputs
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign card_io_out = 1'b0;
    assign card_io_oe = st.drv || st.pdrive
        || (!st.ctrl[C_UART] && st.pwr == P_ON && !st.man);
    assign card_vcc_en = st.vcc;
    assign card_rst_n = st.crst_n;
    assign card_interface_irq = |(st.isr & st.ier);

    read_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_isr |=> st.isr == 6'h00)
        else $error("source read did not clear flags");
    defer_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_isr && ev != '0 |=> ##1 (st.isr & $past(ev, 2)) == $past(ev, 2))
        else $error("event during source read lost");
    wt_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && st.wt_run && !st.locked && st.wt_cnt == 24'h000001
        && !wr_top |=> st.locked && st.isr[EV_WTO])
        else $error("timeout did not lock");
    lock_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st.locked |=> st.seq == S_IDLE)
        else $error("sequencer active while locked");
    wt_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_top && !st.ctrl[C_WAIT_COUNTER_ENABLE] |=> st.wt_cnt == {st.wt2, st.wt1, st.wt0})
        else $error("top byte write did not load counter");
    guard_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st.seq == S_IDLE ##1 st.seq == S_TX
        |-> $past(st.gt_cnt) >= {st.gt1, st.gt0} && st.gt_cnt <= 9'h001)
        else $error("transmit start inside guard time");
    no_card_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st.pwr == P_OFF && !pres |=> st.pwr == P_OFF && !card_vcc_en)
        else $error("power applied without card");
    removal_a: assert property (@(posedge hclk) disable iff (!hresetn)
        st.pwr == P_ON && !pres |=> st.pwr == P_DEACT ##1 !card_rst_n)
        else $error("removal did not deactivate");
endmodule
`default_nettype wire

// *** sim/scia_card_model.sv ***
/*
 Behavioural smart card on the open-drain I/O line: receives characters
 sent by the block and sends characters with good or bad parity.
 Assumes a pull-up on the line and a bit period of ETU_NS nanoseconds.
*/
`timescale 1ns/1ps
`default_nettype none
module scia_card_model #(parameter int ETU_NS = 6400)
(
    input wire logic dut_oe,
    input wire logic inv,
    output logic io_line
);
    logic drive_low = 1'b0;
    logic sending = 1'b0;
    logic [8:0] bits;
    logic [7:0] rx_byte = 8'h00;
    logic par_ok = 1'b0;
    logic err_seen = 1'b0;
    int rx_count = 0;
    // Pulled up: high unless someone pulls low
    assign io_line = ~(dut_oe | drive_low);
    // Logical value to line level and back
    function automatic logic lvl(input logic v);
        return inv ? ~v : v;
    endfunction
    // Start bit, 8 data bits, even parity, then release
    task send_char(input logic [7:0] d, input logic bad);
        sending = 1'b1;
        drive_low = 1'b1;
        #(ETU_NS);
        for (int i = 0; i < 9; i++)
        begin
            drive_low = ~lvl(i < 8 ? d[inv ? 7 - i : i] : (^d) ^ bad);
            #(ETU_NS);
        end
        drive_low = 1'b0;
        #(ETU_NS);
        // Error signal from the block lands mid guard time
        err_seen = ~io_line;
        #(ETU_NS);
        sending = 1'b0;
    endtask
    // Mid-bit sampling of a character from the block
    always
    begin
        @(negedge io_line);
        if (!sending)
        begin
            #(ETU_NS * 3 / 2);
            for (int i = 0; i < 9; i++)
            begin
                bits[i] = lvl(io_line);
                #(ETU_NS);
            end
            for (int i = 0; i < 8; i++)
                rx_byte[inv ? 7 - i : i] = bits[i];
            par_ok = ((^rx_byte) == bits[8]);
            rx_count++;
        end
    end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
/*
 Self-checking bench for the card engine: AHB-Lite master tasks,
 one task per scenario. Assumes the card model in scia_card_model.sv.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import scia_pkg::*;
;
    logic hclk = 1'b0;
    logic card_clk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic card_present = 1'b0;
    logic inv_mode = 1'b0;
    wire logic hreadyout;
    wire logic hresp;
    wire logic [31:0] hrdata;
    wire logic card_io_out;
    wire logic card_io_oe;
    wire logic card_vcc_en;
    wire logic card_rst_n;
    wire logic irq;
    wire logic io_line;
    int n_fail = 0;
    int cmp_count = 0;
    // Clocks; card clock runs free since counters run between frames
    always #25 hclk = ~hclk;
    always #200 card_clk = ~card_clk;
    scia_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .card_clk(card_clk), .card_present(card_present), .card_io_in(io_line),
        .card_io_out(card_io_out), .card_io_oe(card_io_oe),
        .card_vcc_en(card_vcc_en), .card_rst_n(card_rst_n),
        .card_interface_irq(irq));
    scia_card_model #(.ETU_NS(6400)) card_u (.dut_oe(card_io_oe), .inv(inv_mode),
        .io_line(io_line));
    task automatic conclude();
        $display("checks %0d errors %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Bus transfer: address phase, then data phase
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] wd,
        output logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {26'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] d);
        xfer(1'b0, a, 32'h0, d);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] wd);
        logic [31:0] d;
        xfer(1'b1, a, wd, d);
    endtask
    task automatic wait_irq(input int n);
        for (int i = 0; i < n && irq !== 1'b1; i++)
            cyc(1);
    endtask
    task automatic t_regs();
        logic [31:0] d;
        logic [5:0] a[7] = '{A_ETU1, A_ETU0, A_GT0, A_WT2, A_WT1, A_WT0, 6'h3C};
        logic [7:0] e[7] = '{ETU1_RST, ETU0_RST, GT0_RST, WT2_RST, WT1_RST, WT0_RST, 8'h00};
        for (int i = 0; i < 7; i++)
        begin
            rd(a[i], d);
            chk(d, {24'h0, e[i]});
        end
    endtask
    task automatic t_insert();
        logic [31:0] d;
        wr(A_CTRL, 32'h10);
        cyc(100);
        chk({31'h0, card_vcc_en}, 32'h0);
        wr(A_CTRL, 32'h0);
        wr(A_IER, 32'h3F);
        rd(A_ISR, d);
        card_present <= 1'b1;
        wait_irq(40);
        chk({31'h0, irq}, 32'h1);
        rd(A_ISR, d);
        chk(d & 32'h10, 32'h10);
        chk({31'h0, irq}, 32'h0);
        wr(A_ETU1, 32'h0);
        wr(A_ETU0, 32'h10);
        wr(A_CTRL, 32'h11);
        cyc(150);
        chk({30'h0, card_vcc_en, card_rst_n}, 32'h3);
    endtask
    task automatic t_tx(input logic inv, input logic [7:0] b);
        logic [31:0] d;
        int n0;
        inv_mode <= inv;
        wr(A_CTRL, inv ? 32'h15 : 32'h11);
        rd(A_ISR, d);
        n0 = card_u.rx_count;
        wr(A_TXB, {24'h0, b});
        for (int i = 0; i < 4000 && card_u.rx_count == n0; i++)
            cyc(1);
        chk({24'h0, card_u.rx_byte}, {24'h0, b});
        chk({31'h0, card_u.par_ok}, 32'h1);
        chk({31'h0, card_io_out}, 32'h0);
        cyc(250);
        rd(A_ISR, d);
        chk(d & 32'h2, 32'h2);
    endtask
    task automatic t_rx(input logic bad);
        logic [31:0] d;
        logic in_win;
        inv_mode <= 1'b0;
        wr(A_CTRL, 32'h19);
        // Waiting count 971 loaded while disabled, then counting in UART mode
        wr(A_WT1, 32'h03);
        wr(A_WT0, 32'hCB);
        wr(A_WT2, 32'h00);
        wr(A_CTRL, 32'h1B);
        rd(A_ISR, d);
        // Let the counter run down some ten ETU before the start bit
        cyc(1300);
        card_u.send_char(8'h3C, bad);
        wait_irq(300);
        rd(A_ISR, d);
        chk(d & 32'h5, bad ? 32'h4 : 32'h1);
        chk({31'h0, card_u.err_seen}, {31'h0, bad});
        // Reloaded at the start bit: only about twelve ETU down from 971
        in_win = dut_u.st.wt_cnt >= 24'h0003BD && dut_u.st.wt_cnt <= 24'h0003CB;
        chk({31'h0, in_win}, 32'h1);
        rd(A_RXB, d);
        if (!bad)
            chk(d, 32'h3C);
    endtask
    task automatic t_wto();
        logic [31:0] d;
        wr(A_CTRL, 32'h10);
        wr(A_WT0, 32'h5);
        wr(A_WT1, 32'h0);
        wr(A_WT2, 32'h0);
        wr(A_CTRL, 32'h12);
        rd(A_ISR, d);
        cyc(400);
        chk({31'h0, irq}, 32'h0);
        wait_irq(400);
        rd(A_ISR, d);
        chk(d & 32'h8, 32'h8);
        rd(A_STAT, d);
        chk(d & 32'h8, 32'h8);
        wr(A_CTRL, 32'h10);
        wr(A_WT2, 32'h0);
        wr(A_CTRL, 32'h12);
        cyc(5);
        rd(A_STAT, d);
        chk(d & 32'h8, 32'h0);
        wr(A_CTRL, 32'h10);
    endtask
    task automatic t_remove();
        logic [31:0] d;
        rd(A_ISR, d);
        card_present <= 1'b0;
        for (int i = 0; i < 400 && card_vcc_en !== 1'b0; i++)
            cyc(1);
        chk({30'h0, card_vcc_en, card_rst_n}, 32'h0);
        rd(A_ISR, d);
        chk(d & 32'h20, 32'h20);
    endtask
    // Watchdog against a hung handshake
    initial
    begin
        #2000000;
        n_fail++;
        conclude();
    end
    // Main sequence
    initial
    begin
        cyc(12);
        hresetn <= 1'b1;
        t_regs();
        t_insert();
        t_tx(1'b0, 8'hA5);
        t_tx(1'b1, 8'h3B);
        t_rx(1'b0);
        t_rx(1'b1);
        t_wto();
        t_remove();
        conclude();
    end
endmodule
`default_nettype wire
